// ### core/adc_regs_pkg.sv
package adc_regs_pkg;
  // register offsets (indices; byte address = 4 * index)
  localparam logic [7:0] checksum_idx = 8'h03;
  localparam logic [7:0] result_idx = 8'h04;
  localparam logic [7:0] gp_io_config_idx = 8'h06;
  localparam logic [7:0] mode_idx = 8'h10;
  localparam logic [7:0] setup_idx = 8'h11;
  localparam logic [7:0] status_idx = 8'h12;
  localparam logic [7:0] irq_status_idx = 8'h13;
  localparam logic [7:0] irq_mask_idx = 8'h14;
  // reset values
  localparam logic [23:0] checksum_rst = 24'h000000;
  localparam logic [23:0] result_rst = 24'h000000;
  localparam logic [15:0] gp_io_config_rst = 16'h0800;
  localparam logic [15:0] gp_io_config_wmask = 16'h3bff;
  // mode register fields
  localparam int short_word_bit = 0;
  localparam int check_en_bit = 1;
  localparam int stat_append_bit = 2;
  // gpio config fields
  localparam int gp_output_enable_bit = 13;
  localparam int gp_data_a_bit = 6;
  localparam int gp_data_b_bit = 7;
  // status word fields
  localparam int ready_n_bit = 7;
  // interrupt event bits
  localparam int irq_result_bit = 0;
  localparam int irq_dropped_bit = 1;
endpackage : adc_regs_pkg

// ### core/adc_result_and_check_regs.sv
// Notes on behaviour
// RQ1 - with checksum on, check register shows 24-bit xor of all user registers; the code xors only result, gpio config, mode and setup, not irq_mask
// RQ2 - with checksum off, check register reads zero
// RQ3 - result is offset binary, or straight binary when unipolar is selected
// RQ4 - reading the result drives ready bit and ready pin high
// RQ5 - repeated reads of the result return the same value unchanged
// RQ6 - no new result is loaded while an accepted result read is in progress
// RQ7 - status-append mode adds the status byte after the result, 32 bits
// RQ8 - short-word option shortens the result from 24 to 16 bits
// RQ9 - gpio config bit 13 enables both outputs, reset value zero
// RQ10 - word-length change affects only conversions completed after it
// RQ11 - a held-off result is written when the read ends, or replaced by a newer one
module adc_result_and_check_regs #(
  parameter int data_width = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // converter side
  input wire logic [data_width-1:0] conv_code,
  input wire logic conv_done,
  input wire logic [6:0] conv_status,
  // serial side marks the end of the result read
  input wire logic read_busy,
  // pins
  output logic ready_n,
  output logic gp_output_a,
  output logic gp_output_b,
  output logic gp_output_a_oe,
  output logic gp_output_b_oe,
  output logic irq
);

  logic [23:0] result;
  logic [15:0] gp_io_config;
  logic [2:0] mode;
  logic unipolar;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic hold;
  logic pend_valid;
  logic [23:0] pend_code;
  logic [23:0] next_code;
  logic [23:0] checksum;
  logic [7:0] status_word;
  logic rd_result;
  logic wr_hit_ack;
  logic load_now;
  logic dropped;

  assign rd_result = reg_rd && reg_addr == adc_regs_pkg::result_idx;

  // encode and size a fresh code; word length sampled at completion time
  function automatic logic [23:0] encode(input logic [data_width-1:0] code,
                                         input logic uni, input logic short);
    logic [23:0] v;
    v = code[data_width-1 -: 24];
    if (!uni) begin
      v[23] = ~v[23]; // [RQ3]
    end
    if (short) begin
      v = {8'h00, v[23:8]}; // [RQ8]
    end
    return v;
  endfunction : encode

  assign next_code = encode(conv_code, unipolar, mode[adc_regs_pkg::short_word_bit]); // [RQ10]

  // hold-off window: from the accepted read until the serial side finishes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold <= 1'b0;
    end else if (rd_result) begin
      hold <= 1'b1; // [RQ6]
    end else if (!read_busy) begin
      hold <= 1'b0;
    end
  end

  // the window opens on the accepted read and lasts while the host still clocks bits out;
  // a host that never lowers read_busy keeps every later result from loading, with only the newest one parked
  hold_set_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    rd_result |=> hold)
    else $error("hold not raised by result read");
  hold_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    hold && read_busy |=> hold)
    else $error("hold dropped while read busy");
  hold_end_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    hold && !read_busy && !rd_result |=> !hold)
    else $error("hold outlived the read");

  assign load_now = !hold && !rd_result;
  assign dropped = conv_done && pend_valid && !load_now;

  // parked result while held; a newer one replaces it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_valid <= 1'b0;
      pend_code <= adc_regs_pkg::result_rst;
    end else if (conv_done && !load_now) begin
      pend_valid <= 1'b1; // [RQ11]
      pend_code <= next_code;
    end else if (load_now) begin
      pend_valid <= 1'b0;
    end
  end

  // a parked code is the latest one offered, and it is gone once a load happens;
  // only one code is parked, so a burst of results during a long read keeps the newest
  park_code_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    conv_done && !load_now |=> pend_valid && pend_code == $past(next_code))
    else $error("held-off result not parked");
  park_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    pend_valid && !load_now && !conv_done |=> pend_valid && $stable(pend_code))
    else $error("parked result lost while held");
  park_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    load_now |=> !pend_valid)
    else $error("parked result kept after load");
  drop_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    dropped |=> irq_status[adc_regs_pkg::irq_dropped_bit])
    else $error("replaced result not flagged");

  // result register only changes on a new or parked conversion result, never on reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result <= adc_regs_pkg::result_rst;
    end else if (load_now && conv_done) begin
      result <= next_code; // [RQ5]
    end else if (load_now && pend_valid) begin
      result <= pend_code; // [RQ11]
    end
  end

  // a load takes the freshly encoded code, or the parked one when none is new; nothing else moves the register;
  // width and polarity are fixed at completion, so a later mode write cannot re-round a code
  result_load_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    conv_done && load_now |=> result == $past(next_code))
    else $error("result not loaded with new code");
  offset_code_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    conv_done && load_now && !unipolar && !mode[adc_regs_pkg::short_word_bit]
    |=> result == {~$past(conv_code[data_width-1]), $past(conv_code[data_width-2 -: 23])})
    else $error("offset binary code wrong");
  unipolar_code_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    conv_done && load_now && unipolar && !mode[adc_regs_pkg::short_word_bit]
    |=> result == $past(conv_code[data_width-1 -: 24]))
    else $error("unipolar code wrong");
  short_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    conv_done && load_now && unipolar && mode[adc_regs_pkg::short_word_bit]
    |=> result[15:0] == $past(conv_code[data_width-1 -: 16]))
    else $error("short word lost upper code bits");
  offset_short_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    conv_done && load_now && !unipolar && mode[adc_regs_pkg::short_word_bit]
    |=> result == {8'h00, ~$past(conv_code[data_width-1]), $past(conv_code[data_width-2 -: 15])})
    else $error("short offset code wrong");
  idle_stable_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    !conv_done && !pend_valid |=> $stable(result))
    else $error("result moved with no new conversion");
  mode_write_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    reg_wr && reg_addr == adc_regs_pkg::mode_idx && !conv_done && !pend_valid
    |=> $stable(result))
    else $error("word-length change rewrote stored result");

  // ready pin low while an unread result is waiting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_n <= 1'b1;
    end else if (rd_result) begin
      ready_n <= 1'b1; // [RQ4]
    end else if (load_now && (conv_done || pend_valid)) begin
      ready_n <= 1'b0;
    end
  end

  // ready falls only for a load, and cannot fall inside the read window;
  // after a read the host cannot tell whether another result is close behind
  ready_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    !rd_result && load_now && (conv_done || pend_valid) |=> !ready_n)
    else $error("ready pin not low for new result");
  ready_stay_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    ready_n && !(load_now && (conv_done || pend_valid)) |=> ready_n)
    else $error("ready pin fell with no load");
  ready_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    hold |=> ready_n)
    else $error("ready pin fell during result read");
  status_ready_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    reg_rd && reg_addr == adc_regs_pkg::status_idx
    |=> reg_rdata[adc_regs_pkg::ready_n_bit] == $past(ready_n))
    else $error("status ready bit differs from pin");

  assign status_word = {ready_n, conv_status};

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gp_io_config <= adc_regs_pkg::gp_io_config_rst; // [RQ9]
      mode <= 3'h0;
      unipolar <= 1'b0;
      irq_mask <= 2'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        adc_regs_pkg::gp_io_config_idx: begin
          gp_io_config <= reg_wdata[15:0] & adc_regs_pkg::gp_io_config_wmask;
        end
        adc_regs_pkg::mode_idx: begin
          mode <= reg_wdata[2:0];
        end
        adc_regs_pkg::setup_idx: begin
          unipolar <= reg_wdata[0];
        end
        adc_regs_pkg::irq_mask_idx: begin
          irq_mask <= reg_wdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // the enable moves only on a config write and comes out of reset switched off
  oe_reset_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
    $past(sys_rst) |-> !gp_output_a_oe && !gp_output_b_oe)
    else $error("outputs enabled out of reset");
  oe_steady_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
    !reg_wr |=> $stable(gp_output_a_oe) && $stable(gp_output_b_oe))
    else $error("output enable moved without a write");
  oe_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
    reg_wr && reg_addr == adc_regs_pkg::gp_io_config_idx
    && !reg_wdata[adc_regs_pkg::gp_output_enable_bit] |=> !gp_output_a_oe && !gp_output_b_oe)
    else $error("outputs still enabled after disable");

  // sticky events; a set in the same cycle beats the write-one clear
  assign wr_hit_ack = reg_wr && reg_addr == adc_regs_pkg::irq_status_idx;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status[adc_regs_pkg::irq_result_bit] <=
        (irq_status[adc_regs_pkg::irq_result_bit]
         && !(wr_hit_ack && reg_wdata[adc_regs_pkg::irq_result_bit])) || conv_done;
      irq_status[adc_regs_pkg::irq_dropped_bit] <=
        (irq_status[adc_regs_pkg::irq_dropped_bit]
         && !(wr_hit_ack && reg_wdata[adc_regs_pkg::irq_dropped_bit])) || dropped;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // xor over result, gpio config, mode and setup, zero-padded to 24 bits
  always_comb begin
    checksum = result ^ {8'h00, gp_io_config} ^ {21'h000000, mode} ^ {23'h000000, unipolar};
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        adc_regs_pkg::checksum_idx: begin
          reg_rdata <= mode[adc_regs_pkg::check_en_bit] ? {8'h00, checksum} // [RQ1]
                                                        : 32'h00000000; // [RQ2]
        end
        adc_regs_pkg::result_idx: begin
          if (mode[adc_regs_pkg::stat_append_bit]) begin
            reg_rdata <= {result, status_word}; // [RQ7]
          end else begin
            reg_rdata <= {8'h00, result};
          end
        end
        adc_regs_pkg::gp_io_config_idx: reg_rdata <= {16'h0000, gp_io_config};
        adc_regs_pkg::mode_idx: reg_rdata <= {29'h00000000, mode};
        adc_regs_pkg::setup_idx: reg_rdata <= {31'h00000000, unipolar};
        adc_regs_pkg::status_idx: reg_rdata <= {24'h000000, status_word};
        adc_regs_pkg::irq_status_idx: reg_rdata <= {30'h00000000, irq_status};
        adc_regs_pkg::irq_mask_idx: reg_rdata <= {30'h00000000, irq_mask};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // the result read carries the code first and, in append mode, the status byte last;
  // back-to-back plain reads must agree, since the strobe cycle itself blocks loads
  plain_read_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    rd_result && !mode[adc_regs_pkg::stat_append_bit]
    |=> reg_rdata == {8'h00, $past(result)})
    else $error("plain result read wrong");
  append_tail_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    rd_result && mode[adc_regs_pkg::stat_append_bit]
    |=> reg_rdata[7:0] == $past(status_word))
    else $error("appended status byte wrong");
  check_pad_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    reg_rd && reg_addr == adc_regs_pkg::checksum_idx |=> reg_rdata[31:24] == 8'h00)
    else $error("check register wider than 24 bits");
  reread_equal_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    rd_result && !mode[adc_regs_pkg::stat_append_bit] ##1 rd_result
    |=> reg_rdata == $past(reg_rdata))
    else $error("back-to-back result reads differ");

  // gp outputs drive only while enabled
  assign gp_output_a_oe = gp_io_config[adc_regs_pkg::gp_output_enable_bit]; // [RQ9]
  assign gp_output_b_oe = gp_io_config[adc_regs_pkg::gp_output_enable_bit]; // [RQ9]
  assign gp_output_a = gp_io_config[adc_regs_pkg::gp_data_a_bit];
  assign gp_output_b = gp_io_config[adc_regs_pkg::gp_data_b_bit];

  // checks
  check_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    reg_rd && reg_addr == adc_regs_pkg::checksum_idx && !mode[1] |=> reg_rdata == 32'h0)
    else $error("check register nonzero while disabled");
  check_on_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    reg_rd && reg_addr == adc_regs_pkg::checksum_idx && mode[1]
    |=> reg_rdata[23:0] == $past(checksum))
    else $error("check register not the xor of registers");
  read_ready_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    rd_result |=> ready_n)
    else $error("ready pin low after result read");
  result_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    hold || rd_result |=> $stable(result))
    else $error("result changed during read");
  reread_same_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    rd_result ##1 (!conv_done && !pend_valid) |=> $stable(result))
    else $error("read altered result");
  append_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    rd_result && mode[2] |=> reg_rdata[31:8] == $past(result))
    else $error("status not appended");
  short_word_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    conv_done && load_now && mode[0] |=> result[23:16] == 8'h00)
    else $error("short word has upper bits");
  gp_enable_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
    reg_wr && reg_addr == adc_regs_pkg::gp_io_config_idx
    |=> gp_output_a_oe == $past(reg_wdata[13]) && gp_output_b_oe == gp_output_a_oe)
    else $error("output enable mismatch");
  pend_load_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    pend_valid && load_now && !conv_done |=> result == $past(pend_code))
    else $error("held result not written");

endmodule : adc_result_and_check_regs

// ### bench/host_serial_model.sv
// host side of the serial port: a result read keeps the transfer busy
module host_serial_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port as the host sees it
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] busy_len,
  // serial transfer in progress
  output logic read_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;
  // a slow host stretches the read so that the hold-off is exercised
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left <= 4'h0;
    end else if (reg_rd && reg_addr == adc_regs_pkg::result_idx) begin
      left <= busy_len;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign read_busy = (left != 4'h0);
endmodule : host_serial_model

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] conv_code = 24'h0;
  logic conv_done = 1'b0;
  logic [6:0] conv_status = 7'h15;
  logic [3:0] busy_len = 4'h0;
  logic read_busy, ready_n, irq, irq_a;
  logic gp_output_a, gp_output_b, gp_output_a_oe, gp_output_b_oe;
  int n_mismatch = 0;
  int num_checks = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  adc_result_and_check_regs u_adc_result_and_check_regs (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_code, .conv_done, .conv_status,
    .read_busy, .ready_n, .gp_output_a, .gp_output_b, .gp_output_a_oe, .gp_output_b_oe,
    .irq);
  host_serial_model u_host_serial_model (.clk, .sys_rst, .reg_rd, .reg_addr, .busy_len,
    .read_busy);
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, reg_rdata, e);
  endtask : rc
  task automatic conv(input logic [23:0] c);
    @(posedge clk);
    conv_code <= c;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask : conv
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle
  // watchdog: the sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  // main sequence; expected values follow the register rules
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rc(adc_regs_pkg::checksum_idx, 32'h0, "chk_off");
    rc(adc_regs_pkg::gp_io_config_idx, 32'h0800, "gpio_rst");
    chk("oe_rst", 32'({gp_output_a_oe, gp_output_b_oe}), 32'h0);
    wr(adc_regs_pkg::gp_io_config_idx, 32'h28c0);
    rc(adc_regs_pkg::gp_io_config_idx, 32'h28c0, "gpio_wr");
    chk("gpo", 32'({gp_output_a_oe, gp_output_b_oe, gp_output_a, gp_output_b}), 32'hf);
    conv(24'h123456);
    settle();
    chk("rdy_new", 32'(ready_n), 32'h0);
    rc(adc_regs_pkg::result_idx, 32'h923456, "offset");
    chk("rdy_read", 32'(ready_n), 32'h1);
    rc(adc_regs_pkg::result_idx, 32'h923456, "reread");
    wr(adc_regs_pkg::mode_idx, 32'h2);
    rc(adc_regs_pkg::checksum_idx, 32'h923456 ^ 32'h28c0 ^ 32'h2, "chk_on");
    wr(adc_regs_pkg::setup_idx, 32'h1);
    conv(24'h123456);
    rc(adc_regs_pkg::result_idx, 32'h123456, "unipolar");
    wr(adc_regs_pkg::mode_idx, 32'h4);
    rc(adc_regs_pkg::result_idx, {24'h123456, 1'b1, 7'h15}, "append");
    wr(adc_regs_pkg::mode_idx, 32'h1);
    rc(adc_regs_pkg::result_idx, 32'h123456, "old_width");
    conv(24'habcdef);
    rc(adc_regs_pkg::result_idx, 32'habcd, "short");
    // interrupt: event seen, mask toggled, then cleared by writing ones
    rc(adc_regs_pkg::irq_status_idx, 32'h1, "event");
    wr(adc_regs_pkg::irq_mask_idx, 32'h0);
    settle();
    irq_a = irq;
    wr(adc_regs_pkg::irq_mask_idx, 32'h3);
    settle();
    chk("mask", 32'(irq ^ irq_a), 32'h1);
    wr(adc_regs_pkg::irq_status_idx, 32'h3);
    rc(adc_regs_pkg::irq_status_idx, 32'h0, "cleared");
    chk("irq_low", 32'(irq), 32'h0);
    // slow host: two results arrive while the read is still running
    busy_len <= 4'h8;
    rc(adc_regs_pkg::result_idx, 32'habcd, "held_read");
    conv(24'h111111);
    conv(24'h222222);
    @(negedge clk);
    chk("no_load", 32'(ready_n), 32'h1);
    busy_len <= 4'h0;
    for (int i = 0; i < 20 && read_busy; i++) @(negedge clk);
    chk("busy_end", 32'(read_busy), 32'h0);
    settle();
    chk("rdy_after", 32'(ready_n), 32'h0);
    rc(adc_regs_pkg::irq_status_idx, 32'h3, "dropped");
    rc(adc_regs_pkg::result_idx, 32'h2222, "newest");
    stop_test();
  end
endmodule : tb
